//--- logic/crtc_access.sv
// Functional notes
// (R01) priority mux: refresh address unless processor writes
// (R02) interleave: refresh low phase, processor high
// (R03) status bit 5 reads one in vblank
// (R04) processor writes only while bit 5 set
// (R05) transparent: controller drives every memory address
// (R06) transparent interleave: update address in phase 2
// (R07) processor loads update address before access
// (R08) blank update: address only during blanking
// (R09) update strobe marks update address presentation
// (R10) external latch holds write data meanwhile
// (R11) non-interlaced: every line each field
// (R12) interlaced: fields alternate, odd lines offset
// (R13) interlace sync: vsync half line late
// (R14) sync and video: even/odd lines per field
// (R15) mode bits 4/5 skew enable and cursor
// (R16) update address as wide as refresh
`timescale 1ns/1ns
module crtc_access (
	input wire logic clk_sys,
	input wire logic rstn,
	crtc_link_if.crtc link,
	output logic hsync,
	output logic vsync,
	output logic display_enable,
	output logic cursor,
	output logic field_odd
);
	typedef struct packed {
		logic [1:0] div;
		logic [7:0] hcnt;
		logic [4:0] ra;
		logic [6:0] row;
		logic field;
		logic [4:0] vs_cnt;
		logic [13:0] line_base;
		logic [7:0] mode;
		logic [13:0] upd;
		logic [13:0] cur;
		logic pend;
		logic strobe;
		logic de_d;
		logic cur_d;
		logic de_out;
		logic cur_out;
		logic hsync;
		logic vsync;
		logic [13:0] addr_out;
		logic [7:0] rdata;
		logic rvalid;
	} state_t;

	state_t s;
	state_t next_s;
	logic tick;
	logic hblank;
	logic vblank;
	logic disp;
	logic cur_hit;
	logic interl;
	logic video;
	logic transp;
	logic blank_upd;
	logic next_field;
	logic [5:0] ra_next;
	logic [4:0] ra_start;
	logic [13:0] refresh;
	logic [7:0] vs_pos;

	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		tick = s.div == crtc_pkg::CHAR_DIV_LAST;
		hblank = s.hcnt >= crtc_pkg::H_DISP;
		vblank = s.row >= crtc_pkg::V_DISP;
		disp = !hblank && !vblank;
		refresh = s.line_base + {6'h00, s.hcnt};
		cur_hit = disp && (refresh == s.cur);
		interl = s.mode[crtc_pkg::MODE_IL_SYNC];
		video = s.mode[crtc_pkg::MODE_IL_SYNC] && s.mode[crtc_pkg::MODE_IL_VIDEO];
		transp = s.mode[crtc_pkg::MODE_TRANSP];
		blank_upd = s.mode[crtc_pkg::MODE_BLANK_UPD];
		// (R12) field alternates only when interlaced
		next_field = interl ? !s.field : 1'b0;
		// (R14) video mode steps two lines per scan
		ra_next = {1'b0, s.ra} + (video ? 6'h02 : 6'h01);
		ra_start = (video && next_field) ? 5'h01 : 5'h00;
		// (R13) odd field moves vsync edges half a line
		vs_pos = (interl && s.field) ? crtc_pkg::H_HALF : 8'h00;

		next_s.div = tick ? 2'h0 : s.div + 2'h1;

		if (tick) begin
			next_s.hsync = (s.hcnt >= crtc_pkg::H_SYNC_POS) && (s.hcnt < crtc_pkg::H_SYNC_END);
			if (s.hcnt == vs_pos) begin
				next_s.vsync = s.vs_cnt != 5'h00;
			end
			next_s.de_d = disp;
			next_s.cur_d = cur_hit;
			// (R15) one character of skew when the bit is set
			next_s.de_out = s.mode[crtc_pkg::MODE_DE_SKEW] ? s.de_d : disp;
			next_s.cur_out = s.mode[crtc_pkg::MODE_CUR_SKEW] ? s.cur_d : cur_hit;

			if (s.hcnt == crtc_pkg::H_LAST) begin
				next_s.hcnt = 8'h00;
				if (s.vs_cnt != 5'h00) begin
					next_s.vs_cnt = s.vs_cnt - 5'h01;
				end
				// (R11) each scan line once per field; interlace video scans alternate lines
				if (ra_next > {1'b0, crtc_pkg::RA_LAST}) begin
					next_s.line_base = s.line_base + crtc_pkg::ROW_STRIDE;
					next_s.ra = video ? {4'h0, s.field} : 5'h00;
					if (s.row == crtc_pkg::V_LAST) begin
						next_s.row = 7'h00;
						next_s.line_base = 14'h0000;
						next_s.field = next_field;
						next_s.ra = ra_start;
					end else begin
						next_s.row = s.row + 7'h01;
						if (s.row + 7'h01 == crtc_pkg::V_SYNC_ROW) begin
							next_s.vs_cnt = crtc_pkg::V_SYNC_LINES;
						end
					end
				end else begin
					next_s.ra = ra_next[4:0];
				end
			end else begin
				next_s.hcnt = s.hcnt + 8'h01;
			end
		end

		// (R05) in transparent mode all memory addresses come from here
		// pend cleared outside blank mode: a stale load would fire a late strobe after a mode switch
		if (!transp) begin
			next_s.addr_out = refresh;
			next_s.strobe = 1'b0;
			next_s.pend = 1'b0;
		end else if (!blank_upd) begin
			// (R06) phase 2 carries the update address
			next_s.addr_out = link.bus_enable ? s.upd : refresh;
			next_s.strobe = 1'b0;
			next_s.pend = 1'b0;
		end else if (tick) begin
			// (R08) update address only inside blanking
			if (s.pend && (hblank || vblank)) begin
				next_s.addr_out = s.upd;
				// (R09) strobe for the whole character slot
				next_s.strobe = 1'b1;
				next_s.pend = 1'b0;
			end else begin
				next_s.addr_out = refresh;
				next_s.strobe = 1'b0;
			end
		end

		// writes land after the strobe logic so a new load wins over the clear
		if (link.reg_wr) begin
			if (link.reg_addr == crtc_pkg::REG_MODE) begin
				next_s.mode = link.reg_wdata;
			end else if (link.reg_addr == crtc_pkg::REG_CUR_H) begin
				next_s.cur[13:8] = link.reg_wdata[5:0];
			end else if (link.reg_addr == crtc_pkg::REG_CUR_L) begin
				next_s.cur[7:0] = link.reg_wdata;
			end else if (link.reg_addr == crtc_pkg::REG_UPD_H) begin
				// (R16) full fourteen bit update address
				next_s.upd[13:8] = link.reg_wdata[5:0];
			end else if (link.reg_addr == crtc_pkg::REG_UPD_L) begin
				next_s.upd[7:0] = link.reg_wdata;
				next_s.pend = 1'b1;
			end else if (link.reg_addr == crtc_pkg::REG_DUMMY) begin
				// re-arm the same address without reloading it
				next_s.pend = 1'b1;
			end
		end

		if (link.reg_rd) begin
			next_s.rvalid = 1'b1;
			if (link.sel_status) begin
				next_s.rdata = 8'h00;
				// (R03) vertical blanking flag
				next_s.rdata[crtc_pkg::STATUS_VBLANK] = vblank;
			end else if (link.reg_addr == crtc_pkg::REG_CUR_H) begin
				next_s.rdata = {2'b00, s.cur[13:8]};
			end else if (link.reg_addr == crtc_pkg::REG_CUR_L) begin
				next_s.rdata = s.cur[7:0];
			end else begin
				// write-only and unused indices read as zero
				next_s.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.reg_rdata = s.rdata;
	assign link.reg_rvalid = s.rvalid;
	assign link.display_memory_address = s.addr_out;
	assign link.update_strobe = s.strobe;
	assign hsync = s.hsync;
	assign vsync = s.vsync;
	assign display_enable = s.de_out;
	assign cursor = s.cur_out;
	assign field_odd = s.field;
endmodule

//--- logic/crtc_host.sv
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module crtc_host (
	input wire logic clk_sys,
	input wire logic rstn,
	crtc_link_if.host link,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [13:0] vram_addr,
	output logic [7:0] vram_wdata,
	output logic vram_we
);
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_UPD_H,
		ST_UPD_L,
		ST_STROBE,
		ST_PHASE,
		ST_POLL,
		ST_POLL_WAIT,
		ST_WRITE,
		ST_CRD
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic [3:0] ctrl;
		logic [13:0] vaddr;
		logic [7:0] vdata;
		logic e;
		logic [1:0] ecnt;
		logic reg_wr;
		logic reg_rd;
		logic sel_status;
		logic [4:0] reg_addr;
		logic [7:0] reg_wdata;
		logic rack;
		logic [31:0] rdata;
		logic strobe_d;
	} hstate_t;

	hstate_t s;
	hstate_t next_s;
	crtc_pkg::scheme_t scheme;
	logic transp;
	logic blank_upd;
	logic busy_reg;
	logic wr_ok;
	logic cpu_drive;

	always_comb begin
		next_s = s;
		next_s.reg_wr = 1'b0;
		next_s.reg_rd = 1'b0;
		next_s.strobe_d = link.update_strobe;
		scheme = crtc_pkg::scheme_t'(s.ctrl[1:0]);
		transp = s.ctrl[crtc_pkg::CTRL_TRANSP];
		blank_upd = s.ctrl[crtc_pkg::CTRL_BLANK_UPD];
		busy_reg = (address == crtc_pkg::AV_VDATA) || (address == crtc_pkg::AV_CRTC);
		// sequencer and link are single-issue, so those offsets stall while busy
		wr_ok = !busy_reg || (s.st == ST_IDLE);
		waitrequest = (read && !s.rack) || (write && !wr_ok);

		next_s.ecnt = s.ecnt + 2'h1;
		if (s.ecnt == crtc_pkg::E_HALF_LAST) begin
			next_s.e = !s.e;
		end

		case (s.st)
			ST_UPD_H: begin
				// (R07) load the target address first
				next_s.reg_wr = 1'b1;
				next_s.reg_addr = crtc_pkg::REG_UPD_H;
				next_s.reg_wdata = {2'b00, s.vaddr[13:8]};
				next_s.st = ST_UPD_L;
			end
			ST_UPD_L: begin
				next_s.reg_wr = 1'b1;
				next_s.reg_addr = crtc_pkg::REG_UPD_L;
				next_s.reg_wdata = s.vaddr[7:0];
				next_s.st = blank_upd ? ST_STROBE : ST_PHASE;
			end
			ST_STROBE: begin
				if (link.update_strobe && !s.strobe_d) begin
					next_s.st = ST_WRITE;
				end
			end
			ST_PHASE: begin
				// skip a slot while the low update byte is still landing
				if (s.e && (s.ecnt == crtc_pkg::E_WRITE_SLOT) && !s.reg_wr) begin
					next_s.st = ST_WRITE;
				end
			end
			ST_POLL: begin
				next_s.reg_rd = 1'b1;
				next_s.sel_status = 1'b1;
				next_s.st = ST_POLL_WAIT;
			end
			ST_POLL_WAIT: begin
				if (link.reg_rvalid) begin
					// (R04) touch memory only inside vertical blanking
					next_s.st = link.reg_rdata[crtc_pkg::STATUS_VBLANK] ? ST_WRITE : ST_POLL;
				end
			end
			ST_WRITE: begin
				next_s.st = ST_IDLE;
			end
			ST_CRD: begin
				if (link.reg_rvalid) begin
					next_s.rdata = {24'h000000, link.reg_rdata};
					next_s.rack = 1'b1;
					next_s.st = ST_IDLE;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase

		if (read && s.rack) begin
			next_s.rack = 1'b0;
		end else if (read && !s.rack) begin
			if (address == crtc_pkg::AV_CRTC) begin
				if (s.st == ST_IDLE) begin
					next_s.reg_rd = 1'b1;
					next_s.sel_status = 1'b1;
					next_s.st = ST_CRD;
				end
			end else begin
				next_s.rack = 1'b1;
				if (address == crtc_pkg::AV_CTRL) begin
					next_s.rdata = {28'h0000000, s.ctrl};
				end else if (address == crtc_pkg::AV_VADDR) begin
					next_s.rdata = {18'h00000, s.vaddr};
				end else if (address == crtc_pkg::AV_VDATA) begin
					next_s.rdata = {24'h000000, s.vdata};
				end else if (address == crtc_pkg::AV_STATUS) begin
					next_s.rdata = {31'h00000000, s.st != ST_IDLE};
				end else begin
					next_s.rdata = 32'h00000000;
				end
			end
		end

		if (write && wr_ok) begin
			if (address == crtc_pkg::AV_CTRL) begin
				next_s.ctrl = writedata[3:0];
			end else if (address == crtc_pkg::AV_VADDR) begin
				next_s.vaddr = writedata[13:0];
			end else if (address == crtc_pkg::AV_VDATA) begin
				// (R10) data held here until the slot comes
				next_s.vdata = writedata[7:0];
				if (transp) begin
					next_s.st = ST_UPD_H;
				end else if (scheme == crtc_pkg::SCHEME_VBLANK) begin
					next_s.st = ST_POLL;
				end else if (scheme == crtc_pkg::SCHEME_INTERLEAVE) begin
					next_s.st = ST_PHASE;
				end else begin
					next_s.st = ST_WRITE;
				end
			end else if (address == crtc_pkg::AV_CRTC) begin
				next_s.reg_wr = 1'b1;
				next_s.sel_status = 1'b0;
				next_s.reg_addr = writedata[12:8];
				next_s.reg_wdata = writedata[7:0];
			end
		end

		// (R01) processor address overrides at once; (R02) only in the high phase when interleaving
		cpu_drive = (s.st == ST_WRITE) && ((scheme != crtc_pkg::SCHEME_INTERLEAVE) || s.e);
		vram_addr = (transp || !cpu_drive) ? link.display_memory_address : s.vaddr;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign readdata = s.rdata;
	assign vram_wdata = s.vdata;
	assign vram_we = s.st == ST_WRITE;
	assign link.bus_enable = s.e;
	assign link.reg_wr = s.reg_wr;
	assign link.reg_rd = s.reg_rd;
	assign link.sel_status = s.sel_status;
	assign link.reg_addr = s.reg_addr;
	assign link.reg_wdata = s.reg_wdata;
endmodule

//--- logic/crtc_link_if.sv
`timescale 1ns/1ns
interface crtc_link_if;
	logic bus_enable;
	logic reg_wr;
	logic reg_rd;
	logic sel_status;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [13:0] display_memory_address;
	logic update_strobe;

	modport crtc (
		input bus_enable,
		input reg_wr,
		input reg_rd,
		input sel_status,
		input reg_addr,
		input reg_wdata,
		output reg_rdata,
		output reg_rvalid,
		output display_memory_address,
		output update_strobe
	);

	modport host (
		output bus_enable,
		output reg_wr,
		output reg_rd,
		output sel_status,
		output reg_addr,
		output reg_wdata,
		input reg_rdata,
		input reg_rvalid,
		input display_memory_address,
		input update_strobe
	);
endinterface

//--- logic/crtc_pkg.sv
package crtc_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 8;
	localparam int REG_IDX_W = 5;

	// character clock: one tick every four system clocks
	localparam logic [1:0] CHAR_DIV_LAST = 2'h3;

	// fixed raster: 100 characters per line, 80 shown, 10 scan lines per row, 30 rows, 24 shown
	localparam logic [7:0] H_LAST = 8'h63;
	localparam logic [7:0] H_DISP = 8'h50;
	localparam logic [7:0] H_HALF = 8'h32;
	localparam logic [7:0] H_SYNC_POS = 8'h54;
	localparam logic [7:0] H_SYNC_END = 8'h5C;
	localparam logic [4:0] RA_LAST = 5'h09;
	localparam logic [6:0] V_LAST = 7'h1D;
	localparam logic [6:0] V_DISP = 7'h18;
	localparam logic [6:0] V_SYNC_ROW = 7'h1B;
	localparam logic [4:0] V_SYNC_LINES = 5'h04;
	localparam logic [13:0] ROW_STRIDE = 14'h0050;

	// device register indices
	localparam logic [4:0] REG_MODE = 5'h08;
	localparam logic [4:0] REG_CUR_H = 5'h0E;
	localparam logic [4:0] REG_CUR_L = 5'h0F;
	localparam logic [4:0] REG_UPD_H = 5'h12;
	localparam logic [4:0] REG_UPD_L = 5'h13;
	localparam logic [4:0] REG_DUMMY = 5'h1F;

	// mode_control_register fields
	localparam int MODE_IL_SYNC = 0;
	localparam int MODE_IL_VIDEO = 1;
	localparam int MODE_TRANSP = 3;
	localparam int MODE_DE_SKEW = 4;
	localparam int MODE_CUR_SKEW = 5;
	localparam int MODE_BLANK_UPD = 7;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int STATUS_VBLANK = 5;

	// host Avalon byte offsets
	localparam logic [4:0] AV_CTRL = 5'h00;
	localparam logic [4:0] AV_VADDR = 5'h04;
	localparam logic [4:0] AV_VDATA = 5'h08;
	localparam logic [4:0] AV_STATUS = 5'h0C;
	localparam logic [4:0] AV_CRTC = 5'h10;
	localparam int CTRL_TRANSP = 2;
	localparam int CTRL_BLANK_UPD = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// bus enable: four clocks low, four high
	localparam logic [1:0] E_HALF_LAST = 2'h3;
	localparam logic [1:0] E_WRITE_SLOT = 2'h1;

	typedef enum logic [1:0] {
		SCHEME_PRIORITY,
		SCHEME_INTERLEAVE,
		SCHEME_VBLANK,
		SCHEME_SPARE
	} scheme_t;
endpackage

//--- tb/crt_display_memory_access_control_tb_top.sv
`timescale 1ns/1ns
module crt_display_memory_access_control_tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, rq;
	logic waitrequest, hsync, display_enable, field_odd, vram_we, we_be, we_stb, we_de, cursor;
	logic [13:0] vram_addr, we_addr;
	logic [7:0] vram_wdata, we_data;
	int num_errors = 0;
	int n_checks = 0;
	int we_cnt = 0;
	int cyc = 0;
	int we_cyc = 0;
	int g;

	crtc_link_if link ();
	crtc_access u_crtc_access (.clk_sys(clk_sys), .rstn(rstn), .link(link), .hsync(hsync), .vsync(),
		.display_enable(display_enable), .cursor(cursor), .field_odd(field_odd));
	crtc_host u_crtc_host (.clk_sys(clk_sys), .rstn(rstn), .link(link), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.vram_addr(vram_addr), .vram_wdata(vram_wdata), .vram_we(vram_we));
	crtc_access_checker u_crtc_access_checker (.clk_sys(clk_sys), .rstn(rstn), .bus_enable(link.bus_enable),
		.reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .sel_status(link.sel_status), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
		.display_memory_address(link.display_memory_address), .update_strobe(link.update_strobe),
		.display_enable(display_enable), .field_odd(field_odd));

	always #5 clk_sys = ~clk_sys;

	// snapshot of each video RAM write cycle
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (vram_we === 1'b1) begin
			we_addr <= vram_addr;
			we_data <= vram_wdata;
			we_be <= link.bus_enable;
			we_stb <= link.update_strobe;
			we_de <= display_enable;
			we_cyc <= cyc;
			we_cnt <= we_cnt + 1;
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h got %h", nm, exp, got);
		end
	endtask

	task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		read <= rd;
		write <= !rd;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic op(input logic [7:0] mode, input logic [3:0] ctrl, input logic [13:0] va, input logic [7:0] vd);
		int c0;
		c0 = we_cnt;
		av(0, crtc_pkg::AV_CRTC, {19'h0, crtc_pkg::REG_MODE, mode}, rq);
		av(0, crtc_pkg::AV_CTRL, {28'h0, ctrl}, rq);
		av(0, crtc_pkg::AV_VADDR, {18'h0, va}, rq);
		av(0, crtc_pkg::AV_VDATA, {24'h0, vd}, rq);
		for (int n = 0; n < 100000 && we_cnt == c0; n++)
			@(posedge clk_sys);
		chk("we_count", c0 + 1, we_cnt);
		chk("we_addr", {18'h0, va}, {18'h0, we_addr});
		chk("we_data", {24'h0, vd}, {24'h0, we_data});
	endtask

	// clocks from end of display enable to start of horizontal sync
	task automatic de_gap(output int n);
		n = 0;
		while (display_enable !== 1'b1) @(posedge clk_sys);
		while (display_enable !== 1'b0) @(posedge clk_sys);
		while (hsync !== 1'b1) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	// clocks from cursor rise to start of horizontal sync
	task automatic cur_gap(output int n);
		n = 0;
		while (cursor !== 1'b0) @(posedge clk_sys);
		while (cursor !== 1'b1) @(posedge clk_sys);
		while (hsync !== 1'b1) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	// cursor on row 2, column 5; row 2 is still ahead when this runs
	task automatic t_cursor();
		av(0, crtc_pkg::AV_CRTC, {19'h0, crtc_pkg::REG_CUR_H, 8'h00}, rq);
		av(0, crtc_pkg::AV_CRTC, {19'h0, crtc_pkg::REG_CUR_L, 8'hA5}, rq);
		cur_gap(g);
		chk("cur_plain", 4 * (int'(crtc_pkg::H_SYNC_POS) - 5), g);
		av(0, crtc_pkg::AV_CRTC, {19'h0, crtc_pkg::REG_MODE, 8'h30}, rq);
		cur_gap(g);
		chk("cur_skew", 4 * (int'(crtc_pkg::H_SYNC_POS) - 5 - 1), g);
	endtask

	task automatic finish_test();
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		av(1, crtc_pkg::AV_CTRL, 32'h0, rq);
		chk("ctrl_reset", 32'h0, rq);
		av(1, crtc_pkg::AV_STATUS, 32'h0, rq);
		chk("busy_reset", 32'h0, rq);
		av(1, 5'h14, 32'h0, rq);
		chk("unmapped", 32'h0, rq);
		av(1, crtc_pkg::AV_CRTC, 32'h0, rq);
		chk("status_active", 32'h0, rq);
	endtask

	task automatic t_shared();
		op(8'h00, 4'h0, 14'h1234, 8'h5A);
		@(posedge clk_sys);
		chk("idle_refresh", {18'h0, link.display_memory_address}, {18'h0, vram_addr});
		op(8'h00, 4'h1, 14'h0ABC, 8'hA5);
		chk("phase2_write", 32'h1, {31'h0, we_be});
		while (link.bus_enable !== 1'b0) @(posedge clk_sys);
		chk("phase1_refresh", {18'h0, link.display_memory_address}, {18'h0, vram_addr});
	endtask

	task automatic t_skew();
		de_gap(g);
		chk("de_plain", 4 * (int'(crtc_pkg::H_SYNC_POS) - int'(crtc_pkg::H_DISP)), g);
		av(0, crtc_pkg::AV_CRTC, {19'h0, crtc_pkg::REG_MODE, 8'h10}, rq);
		de_gap(g);
		chk("de_skew", 4 * (int'(crtc_pkg::H_SYNC_POS) - int'(crtc_pkg::H_DISP) - 1), g);
	endtask

	task automatic t_transparent();
		op(8'h08, 4'h5, 14'h2ABC, 8'hC3);
		chk("transp_phase2", 32'h1, {31'h0, we_be});
		op(8'h88, 4'hC, 14'h3FFF, 8'h3C);
		chk("transp_strobe", 32'h1, {31'h0, we_stb});
		chk("transp_blank", 32'h0, {31'h0, we_de});
	endtask

	task automatic t_vblank();
		chk("field_even", 32'h0, {31'h0, field_odd});
		op(8'h00, 4'h2, 14'h0100, 8'h77);
		chk("write_in_vblank", 32'h1, {31'h0, we_cyc >= 400 * 10 * int'(crtc_pkg::V_DISP)});
		av(1, crtc_pkg::AV_CRTC, 32'h0, rq);
		chk("status_vblank", 32'h1 << crtc_pkg::STATUS_VBLANK, rq);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_shared();
		t_skew();
		t_cursor();
		t_transparent();
		t_vblank();
		finish_test();
	end

	// the vblank scenario ends near cycle 96000
	initial begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		finish_test();
	end
endmodule

//--- tb/crtc_access_checker.sv
`timescale 1ns/1ns
module crtc_access_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic bus_enable,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic sel_status,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [13:0] display_memory_address,
	input wire logic update_strobe,
	input wire logic display_enable,
	input wire logic field_odd
);
	logic [7:0] mode;
	logic [13:0] upd;

	// shadow of what the host told the device
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode <= 8'h00;
			upd <= 14'h0000;
		end else if (reg_wr) begin
			if (reg_addr == crtc_pkg::REG_MODE)
				mode <= reg_wdata;
			if (reg_addr == crtc_pkg::REG_UPD_H)
				upd[13:8] <= reg_wdata[5:0];
			if (reg_addr == crtc_pkg::REG_UPD_L)
				upd[7:0] <= reg_wdata;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_rvalid_follows_read: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("answer without a read");
	a_status_bit_only: assert property (reg_rvalid && $past(sel_status) |-> (reg_rdata & 8'hDF) == 8'h00)
		else $error("status byte has stray bits");
	a_strobe_four_clocks: assert property ($rose(update_strobe) |-> update_strobe [*4])
		else $error("update strobe too short");
	a_strobe_update_addr: assert property (update_strobe && $stable(upd) |-> display_memory_address == upd)
		else $error("strobe without update address");
	a_phase2_update: assert property (mode[3] && !mode[7] && $stable(mode) && $stable(upd) && bus_enable
		&& $past(bus_enable) |-> display_memory_address == upd)
		else $error("phase 2 address is not the update address");
	a_no_strobe_shared: assert property (!mode[3] && !$past(mode[3], 5) |-> !update_strobe)
		else $error("strobe in shared addressing");
	a_strobe_in_blank: assert property (update_strobe && !mode[4] |-> !display_enable)
		else $error("strobe during active display");
	a_field_stays_even: assert property (!mode[0] && !$past(mode[0]) |-> !field_odd)
		else $error("odd field without interlace");

	c_strobe: cover property ($rose(update_strobe));
	c_vblank_read: cover property (reg_rvalid && $past(sel_status) && reg_rdata[5]);
	c_de_skew: cover property (mode[4] && $fell(display_enable));
endmodule
